/* File: src/bmw_regs.sv */
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module bmw_regs (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        req_valid,
   input  wire logic [63:0] req_addr,
   output logic             fwd_mem,
   output logic             fwd_pref
);
   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   logic        acc;
   logic        wr;
   logic        sel_mem;
   logic        sel_pf;
   logic        sel_bhi;
   logic        sel_lhi;
   logic        mapped;
   logic [31:0] bmask;

   always_comb begin
      acc     = psel && penable && !pready;
      wr      = acc && pwrite;
      sel_mem = 1'b0;
      sel_pf  = 1'b0;
      sel_bhi = 1'b0;
      sel_lhi = 1'b0;
      if (paddr == bmw_pkg::BMW_OFS_MEM) begin
         sel_mem = 1'b1;
      end else if (paddr == bmw_pkg::BMW_OFS_PF) begin
         sel_pf = 1'b1;
      end else if (paddr == bmw_pkg::BMW_OFS_PF_BHI) begin
         sel_bhi = 1'b1;
      end else if (paddr == bmw_pkg::BMW_OFS_PF_LHI) begin
         sel_lhi = 1'b1;
      end
      mapped = sel_mem || sel_pf || sel_bhi || sel_lhi;
      for (int i = 0; i < 4; i++) begin
         bmask[i*8 +: 8] = {8{pstrb[i]}};
      end
   end

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [11:0] mem_base;
   logic [11:0] mem_limit;
   logic [11:0] pf_base;
   logic [11:0] pf_limit;
   logic [31:0] pf_bhi;
   logic [31:0] pf_lhi;

   // Low nibbles are never stored, so reserved and indicator bits ignore writes
   bmw_field #(.W(bmw_pkg::BMW_FLD_W), .RST(bmw_pkg::BMW_FLD_RST)) u_mem_base (
      .clk   (clk),
      .nrst  (nrst),
      .we    (wr && sel_mem),
      .wmask (bmask[bmw_pkg::BMW_BASE_LSB +: bmw_pkg::BMW_FLD_W]),
      .wdata (pwdata[bmw_pkg::BMW_BASE_LSB +: bmw_pkg::BMW_FLD_W]),
      .q_r   (mem_base)
   );

   bmw_field #(.W(bmw_pkg::BMW_FLD_W), .RST(bmw_pkg::BMW_FLD_RST)) u_mem_limit (
      .clk   (clk),
      .nrst  (nrst),
      .we    (wr && sel_mem),
      .wmask (bmask[bmw_pkg::BMW_LIMIT_LSB +: bmw_pkg::BMW_FLD_W]),
      .wdata (pwdata[bmw_pkg::BMW_LIMIT_LSB +: bmw_pkg::BMW_FLD_W]),
      .q_r   (mem_limit)
   );

   bmw_field #(.W(bmw_pkg::BMW_FLD_W), .RST(bmw_pkg::BMW_FLD_RST)) u_pf_base (
      .clk   (clk),
      .nrst  (nrst),
      .we    (wr && sel_pf),
      .wmask (bmask[bmw_pkg::BMW_BASE_LSB +: bmw_pkg::BMW_FLD_W]),
      .wdata (pwdata[bmw_pkg::BMW_BASE_LSB +: bmw_pkg::BMW_FLD_W]),
      .q_r   (pf_base)
   );

   bmw_field #(.W(bmw_pkg::BMW_FLD_W), .RST(bmw_pkg::BMW_FLD_RST)) u_pf_limit (
      .clk   (clk),
      .nrst  (nrst),
      .we    (wr && sel_pf),
      .wmask (bmask[bmw_pkg::BMW_LIMIT_LSB +: bmw_pkg::BMW_FLD_W]),
      .wdata (pwdata[bmw_pkg::BMW_LIMIT_LSB +: bmw_pkg::BMW_FLD_W]),
      .q_r   (pf_limit)
   );

   bmw_field #(.W(32), .RST(bmw_pkg::BMW_HI_RST)) u_pf_bhi (
      .clk   (clk),
      .nrst  (nrst),
      .we    (wr && sel_bhi),
      .wmask (bmask),
      .wdata (pwdata),
      .q_r   (pf_bhi)
   );

   bmw_field #(.W(32), .RST(bmw_pkg::BMW_HI_RST)) u_pf_lhi (
      .clk   (clk),
      .nrst  (nrst),
      .we    (wr && sel_lhi),
      .wmask (bmask),
      .wdata (pwdata),
      .q_r   (pf_lhi)
   );

   // ----------------------------------------
   // Read data and answer
   // ----------------------------------------
   logic [31:0] rdata;
   logic [31:0] prdata_nxt;
   logic        pready_nxt;
   logic        pslverr_nxt;

   always_comb begin
      rdata = bmw_pkg::BMW_ZERO32;
      if (sel_mem) begin
         rdata = {mem_limit, 4'h0, mem_base, 4'h0};
      end else if (sel_pf) begin
         rdata = {pf_limit, bmw_pkg::BMW_IND_64, pf_base, bmw_pkg::BMW_IND_64};
      end else if (sel_bhi) begin
         rdata = pf_bhi;
      end else if (sel_lhi) begin
         rdata = pf_lhi;
      end
      pready_nxt  = acc;
      pslverr_nxt = acc && !mapped;
      prdata_nxt  = prdata;
      if (acc && !pwrite) begin
         prdata_nxt = rdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         prdata  <= bmw_pkg::BMW_ZERO32;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= prdata_nxt;
         pready  <= pready_nxt;
         pslverr <= pslverr_nxt;
      end
   end

   // ----------------------------------------
   // Windows and forwarding decision
   // ----------------------------------------
   bmw_pkg::bmw_win_t mem_win;
   bmw_pkg::bmw_win_t pf_win;

   always_comb begin
      mem_win.bottom = {bmw_pkg::BMW_ZERO32, mem_base, bmw_pkg::BMW_LOW_ZERO};
      mem_win.top    = {bmw_pkg::BMW_ZERO32, mem_limit, bmw_pkg::BMW_LOW_ONES};
      pf_win.bottom  = {pf_bhi, pf_base, bmw_pkg::BMW_LOW_ZERO};
      pf_win.top     = {pf_lhi, pf_limit, bmw_pkg::BMW_LOW_ONES};
   end

   bmw_match u_mem_match (
      .clk       (clk),
      .nrst      (nrst),
      .req_valid (req_valid),
      .req_addr  (req_addr),
      .win       (mem_win),
      .hit_r     (fwd_mem)
   );

   bmw_match u_pf_match (
      .clk       (clk),
      .nrst      (nrst),
      .req_valid (req_valid),
      .req_addr  (req_addr),
      .win       (pf_win),
      .hit_r     (fwd_pref)
   );
endmodule

/* File: src/bmw_pkg.sv */
// Overview of operation
// - The memory window base keeps a writable 12-bit field in bits 15:4 for address bits 31:20, reset to zero.
// - The memory window bottom takes address bits 19:0 as zero, so it is 1 MB aligned.
// - The memory window limit keeps a writable 12-bit field in bits 31:20 for address bits 31:20, with bits 19:0 of the top taken as all ones.
// - The port forwards a memory request between its interfaces by the memory window base and limit.
// - The low four bits of the prefetch base and prefetch limit fields are read-only and read as one.
// - The prefetch base keeps a writable 12-bit field at bits 15:4 for address bits 31:20, lower 20 bits zero, reset to zero.
// - The prefetch limit keeps a writable 12-bit field at bits 31:20 for address bits 31:20, lower 20 bits all ones, reset to zero.
// - The prefetch window bottom is a 64-bit address whose upper half comes from the base-upper register.
// - The prefetch window top is a 64-bit address whose upper half comes from the limit-upper register.
// - The base-upper register is a fully writable 32-bit field for bits 63:32 of the bottom, reset to zero.
// - The port forwards memory reads and writes between its interfaces by the 64-bit prefetch base and limit.
// - The limit-upper register is a fully writable 32-bit field for bits 63:32 of the top, at its own offset, reset to zero.
package bmw_pkg;
   localparam logic [7:0]  BMW_OFS_MEM     = 8'h20;
   localparam logic [7:0]  BMW_OFS_PF      = 8'h24;
   localparam logic [7:0]  BMW_OFS_PF_BHI  = 8'h28;
   localparam logic [7:0]  BMW_OFS_PF_LHI  = 8'h2C;
   localparam int          BMW_BASE_LSB    = 4;
   localparam int          BMW_LIMIT_LSB   = 20;
   localparam int          BMW_FLD_W       = 12;
   localparam int          BMW_IND_LIMIT   = 16;
   localparam logic [3:0]  BMW_IND_64      = 4'h1;
   localparam logic [11:0] BMW_FLD_RST     = 12'h000;
   localparam logic [31:0] BMW_HI_RST      = 32'h00000000;
   localparam logic [19:0] BMW_LOW_ZERO    = 20'h00000;
   localparam logic [19:0] BMW_LOW_ONES    = 20'hFFFFF;
   localparam logic [31:0] BMW_ZERO32      = 32'h00000000;

   typedef struct packed {
      logic [63:0] bottom;
      logic [63:0] top;
   } bmw_win_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } bmw_apb_req_t;
endpackage

/* File: src/bmw_field.sv */
`timescale 1ns/1ps
module bmw_field #(
   parameter int           W   = 12,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         we,
   input  wire logic [W-1:0] wmask,
   input  wire logic [W-1:0] wdata,
   output logic      [W-1:0] q_r
);
   logic [W-1:0] q_nxt;

   // Lanes outside the mask keep their old value, so partial writes are safe
   always_comb begin
      q_nxt = (q_r & ~wmask) | (wdata & wmask);
      if (!we) begin
         q_nxt = q_r;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         q_r <= RST;
      end else begin
         q_r <= q_nxt;
      end
   end
endmodule

/* File: src/bmw_match.sv */
`timescale 1ns/1ps
module bmw_match (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic             req_valid,
   input  wire logic [63:0]      req_addr,
   input  wire bmw_pkg::bmw_win_t win,
   output logic                  hit_r
);
   logic hit_nxt;

   // Inverted window fails the bottom <= top check, so it stays empty
   always_comb begin
      hit_nxt = req_valid && (win.bottom <= win.top)
                && (req_addr >= win.bottom) && (req_addr <= win.top);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         hit_r <= 1'b0;
      end else begin
         hit_r <= hit_nxt;
      end
   end
endmodule

/* File: verif/bmw_regs_monitor.sv */
`timescale 1ns/1ps
// ----
// Port checker
// ----
module bmw_regs_monitor (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        req_valid,
   input wire logic [63:0] req_addr,
   input wire logic        fwd_mem,
   input wire logic        fwd_pref
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no answer one cycle after access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_unmapped: assert property (pready || pslverr |->
      pready && pslverr == !(paddr inside {8'h20, 8'h24, 8'h28, 8'h2C}))
      else $error("error flag wrong for address");
   a_pf_nibble: assert property (
      pready && !pwrite && paddr == 8'h24 |-> prdata[3:0] == 4'h1 && prdata[19:16] == 4'h1)
      else $error("prefetch indicator not one");
   a_mem_rsvd: assert property (
      pready && !pwrite && paddr == 8'h20 |-> prdata[3:0] == 4'h0 && prdata[19:16] == 4'h0)
      else $error("reserved bits not zero");
   a_mem_upper: assert property (
      req_valid && req_addr[63:32] != 32'h0 |=> !fwd_mem)
      else $error("memory hit above 4 GB");
   a_idle_no_fwd: assert property (!req_valid |=> !fwd_mem && !fwd_pref)
      else $error("forward without request");
   a_reset_clear: assert property ($rose(nrst) |-> !pready && !pslverr && !fwd_mem && !fwd_pref)
      else $error("outputs not clear after reset");
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin \
   checked++; \
   if ((a) !== (b)) begin \
      bad_count++; \
      $display("ERROR %0t: got %h exp %h", $time, a, b); \
   end \
end
// ----
// Bench
// ----
module tb_top;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [3:0]  pstrb = 4'hF;
   logic        req_valid = 1'b0;
   logic        rv_d = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] r;
   logic [63:0] req_addr = 64'h0;
   logic        pready;
   logic        pslverr;
   logic        fwd_mem;
   logic        fwd_pref;
   logic [32:0] rq[$];
   logic [1:0]  fq[$];
   logic [32:0] er;
   logic [1:0]  ef;
   int          bad_count = 0;
   int          checked = 0;
   int          cyc = 0;
   always #5 clk = ~clk;
   bmw_regs dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .req_valid(req_valid), .req_addr(req_addr), .fwd_mem(fwd_mem),
      .fwd_pref(fwd_pref));
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      // No local limit: only the bench timeout may end a hung wait
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
      rq.push_back({err, e});
      apb(1'b0, a, 32'h0);
   endtask
   task automatic req(input logic [63:0] a, input logic [1:0] e);
      req_valid <= 1'b1;
      req_addr <= a;
      fq.push_back(e);
      @(posedge clk);
   endtask
   task automatic summarize;
      if (rq.size() != 0 || fq.size() != 0) begin
         bad_count++;
         $display("ERROR %0t: results still expected", $time);
      end
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ----
   // Watcher, takes the oldest note per result
   // ----
   always @(posedge clk) begin
      rv_d <= req_valid;
      cyc++;
      // Pop once into a local, the macro reads its arguments twice
      if (pready === 1'b1 && pwrite === 1'b0) begin
         er = (rq.size() > 0) ? rq.pop_front() : 'x;
         `CHK({pslverr, prdata}, er)
      end
      if (rv_d) begin
         ef = (fq.size() > 0) ? fq.pop_front() : 'x;
         `CHK({fwd_mem, fwd_pref}, ef)
      end
      if (cyc > 3000) begin
         bad_count++;
         summarize();
      end
   end
   initial begin
      r = $urandom(32'h278a);
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(8'h20, 32'h0);
      rd(8'h24, 32'h00010001);
      rd(8'h28, 32'h0);
      rd(8'h2C, 32'h0);
      $display("test reset values done");
      apb(1'b1, 8'h20, 32'hFFFFFFFF);
      rd(8'h20, 32'hFFF0FFF0);
      apb(1'b1, 8'h24, 32'hFFFFFFFF);
      rd(8'h24, 32'hFFF1FFF1);
      r = $urandom() | 32'h1;
      apb(1'b1, 8'h28, r);
      apb(1'b1, 8'h2C, r);
      rd(8'h28, r);
      rd(8'h2C, r);
      apb(1'b1, 8'h28, 32'h0, 4'h1);
      rd(8'h28, {r[31:8], 8'h00});
      apb(1'b1, 8'h28, r);
      apb(1'b1, 8'h30, 32'hFFFFFFFF);
      rd(8'h30, 32'h0, 1'b1);
      $display("test register access done");
      apb(1'b1, 8'h20, 32'h1FF01000);
      apb(1'b1, 8'h24, 32'h00200010);
      req(64'h10000000, 2'b10);
      req(64'h0FFFFFFF, 2'b00);
      req(64'h1FFFFFFF, 2'b10);
      req(64'h20000000, 2'b00);
      req(64'h110000000, 2'b00);
      req({r, 32'h00100000}, 2'b01);
      req({r, 32'h000FFFFF}, 2'b00);
      req({r, 32'h002FFFFF}, 2'b01);
      req({r, 32'h00300000}, 2'b00);
      req({r + 32'h1, 32'h00200000}, 2'b00);
      req_valid <= 1'b0;
      @(posedge clk);
      $display("test decode done");
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(8'h20, 32'h0);
      rd(8'h24, 32'h00010001);
      rd(8'h28, 32'h0);
      $display("test mid-run reset done");
      apb(1'b1, 8'h20, 32'h00F01000);
      req(64'h10000000, 2'b00);
      req_valid <= 1'b0;
      repeat (2) @(posedge clk);
      $display("test empty window done");
      summarize();
   end
endmodule
bind bmw_regs bmw_regs_monitor mon (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_addr(req_addr),
   .fwd_mem(fwd_mem), .fwd_pref(fwd_pref));
